// File: pkg/rpo_cfg.svh
`ifndef RPO_CFG_SVH
`define RPO_CFG_SVH

// Count source dividers (system clock / N)
`define RPO_DIV_FAST      5'h02
`define RPO_DIV_SLOW      5'h10

// Highest pointer used by each repeated mode
`define RPO_TOP_8REP      3'h7
`define RPO_TOP_6REP      3'h5
`define RPO_TOP_5REP      3'h4

// One-shot sequence pointers
`define RPO_OS_START_REG  3'h1
`define RPO_OS_PTR_START  3'h0
`define RPO_OS_PTR_MID    3'h2
`define RPO_OS_PTR_DONE   3'h1

// Reset values
`define RPO_PTR_RST       3'h7
`define RPO_WPTR_RST      1'h1
`define RPO_STOP_RST      1'h1
`define RPO_LATCH_RST     16'h0000

// Counter terminal value and latch indices
`define RPO_CNT_ZERO      16'h0000
`define RPO_LATCH_FIRST   1'h1
`define RPO_LATCH_SECOND  1'h0

`endif

// File: pkg/rpo_pkg.sv
package rpo_pkg;

  // Channel operating mode
  typedef enum logic [1:0] {
    RPO_MODE_8REP    = 2'h0,
    RPO_MODE_6REP    = 2'h1,
    RPO_MODE_5REP    = 2'h2,
    RPO_MODE_ONESHOT = 2'h3
  } rpo_mode_e;

  // Channel sequencer state
  typedef enum logic [3:0] {
    RPO_ST_IDLE    = 4'h1,
    RPO_ST_REPEAT  = 4'h2,
    RPO_ST_OS_MID  = 4'h4,
    RPO_ST_OS_LAST = 4'h8
  } rpo_state_e;

endpackage : rpo_pkg

// File: logic/rpo_timer16.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpo_cfg.svh"

module rpo_timer16 #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Control
  input  wire logic         cnt_pulse,
  input  wire logic         start,
  input  wire logic         running,
  // Latch write side
  input  wire logic         lat_wr_lo,
  input  wire logic         lat_wr_hi,
  input  wire logic [7:0]   lat_wdata,
  input  wire logic         wptr_preset,
  input  wire logic         wptr_value,
  // Read side
  input  wire logic         rd_hi,
  input  wire logic         rd_lo,
  output logic      [7:0]   rd_data,
  // Status
  output logic              underflow,
  output logic              wptr
);

  logic [W-1:0] cnt_reg, cnt_next;
  logic [W-1:0] lat0_reg, lat0_next;
  logic [W-1:0] lat1_reg, lat1_next;
  logic [7:0]   lo_pend_reg, lo_pend_next;
  logic         wptr_reg, wptr_next;
  logic         rsel_reg, rsel_next;
  logic [7:0]   hold_reg, hold_next;
  logic         held_reg, held_next;
  logic [7:0]   rd_reg, rd_next;

  assign underflow = cnt_pulse && running && !start && (cnt_reg == `RPO_CNT_ZERO);
  assign rd_data   = rd_reg;
  assign wptr      = wptr_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cnt_next     = cnt_reg;
    rsel_next    = rsel_reg;
    lat0_next    = lat0_reg;
    lat1_next    = lat1_reg;
    lo_pend_next = lo_pend_reg;
    wptr_next    = wptr_reg;
    hold_next    = hold_reg;
    held_next    = held_reg;
    rd_next      = rd_reg;
    if (start) begin
      cnt_next  = lat1_reg;
      rsel_next = `RPO_LATCH_SECOND;
    end else if (cnt_pulse && running) begin
      if (cnt_reg == `RPO_CNT_ZERO) begin
        cnt_next  = rsel_reg ? lat1_reg : lat0_reg;
        rsel_next = ~rsel_reg;
      end else begin
        cnt_next = cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
    end
    // Writes only reach the latches; the counter sees them when it next reloads from that latch
    if (lat_wr_lo) begin
      lo_pend_next = lat_wdata;
    end
    if (wptr_preset) begin
      wptr_next = wptr_value;
    end else if (lat_wr_hi) begin
      if (wptr_reg) begin
        lat1_next = {lat_wdata, lo_pend_reg};
      end else begin
        lat0_next = {lat_wdata, lo_pend_reg};
      end
      wptr_next = ~wptr_reg;
    end
    if (rd_hi) begin
      rd_next   = cnt_reg[W-1:W-8];
      hold_next = cnt_reg[7:0];
      held_next = 1'b1;
    end else if (rd_lo) begin
      rd_next   = held_reg ? hold_reg : cnt_reg[7:0];
      held_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg     <= `RPO_CNT_ZERO;
      rsel_reg    <= `RPO_LATCH_FIRST;
      lat0_reg    <= `RPO_LATCH_RST;
      lat1_reg    <= `RPO_LATCH_RST;
      lo_pend_reg <= 8'h00;
      wptr_reg    <= `RPO_WPTR_RST;
      hold_reg    <= 8'h00;
      held_reg    <= 1'b0;
      rd_reg      <= 8'h00;
    end else begin
      cnt_reg     <= cnt_next;
      rsel_reg    <= rsel_next;
      lat0_reg    <= lat0_next;
      lat1_reg    <= lat1_next;
      lo_pend_reg <= lo_pend_next;
      wptr_reg    <= wptr_next;
      hold_reg    <= hold_next;
      held_reg    <= held_next;
      rd_reg      <= rd_next;
    end
  end

endmodule : rpo_timer16
`default_nettype wire

// File: logic/rpo_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpo_cfg.svh"


module rpo_top #(
  parameter int NCH  = 2,
  parameter int NPAT = 8
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Shared configuration
  input  wire logic                  cnt_src_slow,
  input  wire logic                  trig_edge_rise,
  input  wire logic                  external_trigger_pin,
  // Pattern register write and read
  input  wire logic                  pat_wr,
  input  wire logic [2:0]            pat_wr_idx,
  input  wire logic [7:0]            pat_wr_data,
  input  wire logic [2:0]            pat_rd_idx,
  output logic      [7:0]            pat_rd_data,
  // Per-channel configuration
  input  wire logic [NCH-1:0][1:0]   ch_mode,
  input  wire logic [NCH-1:0]        ch_trig_ext,
  input  wire logic [NCH-1:0]        ch_stop_set,
  input  wire logic [NCH-1:0]        ch_ptr_wr,
  input  wire logic [NCH-1:0][2:0]   ch_ptr_data,
  input  wire logic [NCH-1:0]        ch_irq_ptr_mode,
  input  wire logic [NCH-1:0][2:0]   ch_irq_ptr_match,
  input  wire logic [NCH-1:0]        ch_irq_clr,
  // Per-channel timer latch access
  input  wire logic [NCH-1:0]        ch_lat_wr_lo,
  input  wire logic [NCH-1:0]        ch_lat_wr_hi,
  input  wire logic [7:0]            lat_wdata,
  input  wire logic [NCH-1:0]        ch_wptr_preset,
  input  wire logic [NCH-1:0]        ch_wptr_value,
  input  wire logic [NCH-1:0]        ch_rd_hi,
  input  wire logic [NCH-1:0]        ch_rd_lo,
  output logic      [NCH-1:0][7:0]   ch_rd_data,
  // Per-channel status
  output logic      [NCH-1:0]        ch_count_stopped,
  output logic      [NCH-1:0][2:0]   ch_out_ptr,
  output logic      [NCH-1:0]        ch_wptr,
  output logic      [NCH-1:0]        ch_irq_flag,
  output logic      [NCH-1:0]        ch_busy,
  // Pattern outputs
  output logic      [NCH-1:0][7:0]   pattern_output_port
);

  ////////////////////////////////////////////////////////////////////////////
  // Pattern registers

  logic [7:0] pat_reg  [0:NPAT-1];
  logic [7:0] pat_next [0:NPAT-1];
  logic [7:0] rd_reg, rd_next;

  assign pat_rd_data = rd_reg;

  always_comb begin
    for (int i = 0; i < NPAT; i++) begin
      pat_next[i] = pat_reg[i];
    end
    if (pat_wr) begin
      pat_next[pat_wr_idx] = pat_wr_data;
    end
    rd_next = pat_reg[pat_rd_idx];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NPAT; i++) begin
        pat_reg[i] <= 8'h00;
      end
      rd_reg <= 8'h00;
    end else begin
      for (int i = 0; i < NPAT; i++) begin
        pat_reg[i] <= pat_next[i];
      end
      rd_reg <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared count source prescaler and trigger pin edge detect

  logic [4:0] pre_reg, pre_next;
  logic       pin_reg, pin_next;
  logic       cnt_pulse;
  logic [4:0] div_last;
  logic       pin_rise, pin_fall;

  assign div_last  = (cnt_src_slow ? `RPO_DIV_SLOW : `RPO_DIV_FAST) - 5'h01;
  assign cnt_pulse = (pre_reg >= div_last);
  assign pin_rise  = external_trigger_pin && !pin_reg;
  assign pin_fall  = !external_trigger_pin && pin_reg;

  always_comb begin
    pre_next = cnt_pulse ? 5'h00 : pre_reg + 5'h01;
    pin_next = external_trigger_pin;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pre_reg <= 5'h00;
      // Follow the pin through reset so a level held across release is no edge
      pin_reg <= pin_next;
    end else begin
      pre_reg <= pre_next;
      pin_reg <= pin_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    rpo_pkg::rpo_mode_e  mode;
    rpo_pkg::rpo_state_e st_reg, st_next;
    logic [2:0] ptr_reg, ptr_next;
    logic [2:0] top;
    logic [2:0] ptr_dec;
    logic [7:0] out_reg, out_next;
    logic       stop_reg, stop_next;
    logic       irq_reg, irq_next;
    logic       oneshot;
    logic       start;
    logic       uflow;
    logic       irq_hit;

    assign mode    = rpo_pkg::rpo_mode_e'(ch_mode[c]);
    assign oneshot = (mode == rpo_pkg::RPO_MODE_ONESHOT);

    // Trigger select matters only in one-shot, where external means both edges
    always_comb begin
      if (ch_trig_ext[c] && oneshot) begin
        start = pin_rise || pin_fall;
      end else begin
        start = trig_edge_rise ? pin_rise : pin_fall;
      end
    end

    always_comb begin
      unique case (mode)
        rpo_pkg::RPO_MODE_8REP: top = `RPO_TOP_8REP;
        rpo_pkg::RPO_MODE_6REP: top = `RPO_TOP_6REP;
        rpo_pkg::RPO_MODE_5REP: top = `RPO_TOP_5REP;
        rpo_pkg::RPO_MODE_ONESHOT: top = `RPO_OS_PTR_MID;
      endcase
    end
    // A pointer above the mode's top still walks down, then wraps to top
    assign ptr_dec = (ptr_reg == 3'h0) ? top : ptr_reg - 3'h1;

    rpo_timer16 #(
      .W (16)
    ) u_timer (
      .clk         (clk),
      .srst        (srst),
      .cnt_pulse   (cnt_pulse),
      .start       (start),
      .running     (!stop_reg),
      .lat_wr_lo   (ch_lat_wr_lo[c]),
      .lat_wr_hi   (ch_lat_wr_hi[c]),
      .lat_wdata   (lat_wdata),
      .wptr_preset (ch_wptr_preset[c]),
      .wptr_value  (ch_wptr_value[c]),
      .rd_hi       (ch_rd_hi[c]),
      .rd_lo       (ch_rd_lo[c]),
      .rd_data     (ch_rd_data[c]),
      .underflow   (uflow),
      .wptr        (ch_wptr[c])
    );

    assign irq_hit = uflow && (!ch_irq_ptr_mode[c] || (ptr_reg == ch_irq_ptr_match[c]));

    always_comb begin
      st_next   = st_reg;
      ptr_next  = ptr_reg;
      out_next  = out_reg;
      stop_next = stop_reg;
      // Set wins over a clear in the same cycle
      irq_next  = irq_hit ? 1'b1 : (ch_irq_clr[c] ? 1'b0 : irq_reg);
      if (ch_stop_set[c]) begin
        stop_next = 1'b1;
      end
      if (ch_ptr_wr[c] && !oneshot) begin
        ptr_next = ch_ptr_data[c];
      end
      if (start) begin
        stop_next = 1'b0;
        if (oneshot) begin
          out_next = pat_reg[`RPO_OS_START_REG];
          ptr_next = `RPO_OS_PTR_START;
          st_next  = rpo_pkg::RPO_ST_OS_MID;
        end else begin
          out_next = pat_reg[ptr_reg];
          ptr_next = ptr_dec;
          st_next  = rpo_pkg::RPO_ST_REPEAT;
        end
      end else if (uflow) begin
        unique case (st_reg)
          rpo_pkg::RPO_ST_IDLE: begin
            st_next = rpo_pkg::RPO_ST_IDLE;
          end
          rpo_pkg::RPO_ST_REPEAT: begin
            out_next = pat_reg[ptr_reg];
            ptr_next = ptr_dec;
          end
          rpo_pkg::RPO_ST_OS_MID: begin
            out_next = pat_reg[ptr_reg];
            ptr_next = `RPO_OS_PTR_MID;
            st_next  = rpo_pkg::RPO_ST_OS_LAST;
          end
          rpo_pkg::RPO_ST_OS_LAST: begin
            // Stopping the timer here keeps stray reloads off the held pattern
            out_next  = pat_reg[`RPO_OS_PTR_MID];
            ptr_next  = `RPO_OS_PTR_DONE;
            stop_next = 1'b1;
            st_next   = rpo_pkg::RPO_ST_IDLE;
          end
          default: begin
            // A corrupted one-hot code falls back to waiting for a trigger
            st_next = rpo_pkg::RPO_ST_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        st_reg   <= rpo_pkg::RPO_ST_IDLE;
        ptr_reg  <= `RPO_PTR_RST;
        out_reg  <= 8'h00;
        stop_reg <= `RPO_STOP_RST;
        irq_reg  <= 1'b0;
      end else begin
        st_reg   <= st_next;
        ptr_reg  <= ptr_next;
        out_reg  <= out_next;
        stop_reg <= stop_next;
        irq_reg  <= irq_next;
      end
    end

    assign pattern_output_port[c] = out_reg;
    assign ch_out_ptr[c]          = ptr_reg;
    assign ch_count_stopped[c]    = stop_reg;
    assign ch_irq_flag[c]         = irq_reg;
    assign ch_busy[c]             = (st_reg != rpo_pkg::RPO_ST_IDLE);
  end

endmodule : rpo_top
`default_nettype wire

// File: verification/rpo_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rpo_top_checker #(
  parameter int NCH = 2
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                srst,
  // Stimulus seen by the block
  input wire logic                trig_edge_rise,
  input wire logic                external_trigger_pin,
  input wire logic [NCH-1:0][1:0] ch_mode,
  input wire logic [NCH-1:0]      ch_trig_ext,
  input wire logic [NCH-1:0]      ch_ptr_wr,
  input wire logic [NCH-1:0][2:0] ch_ptr_data,
  input wire logic [NCH-1:0]      ch_lat_wr_hi,
  input wire logic [NCH-1:0]      ch_wptr_preset,
  input wire logic [NCH-1:0]      ch_wptr_value,
  // Block outputs
  input wire logic [NCH-1:0]      ch_count_stopped,
  input wire logic [NCH-1:0][2:0] ch_out_ptr,
  input wire logic [NCH-1:0]      ch_wptr,
  input wire logic [NCH-1:0]      ch_irq_flag,
  input wire logic [NCH-1:0]      ch_busy,
  input wire logic [NCH-1:0][7:0] pattern_output_port
);
  logic [2:0] top0;

  // Wrap target of channel 0 in the repeated modes
  assign top0 = (ch_mode[0] == 2'h0) ? 3'h7 : (ch_mode[0] == 2'h1) ? 3'h5 : 3'h4;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////////
  a_reset_state: assert property ($fell(srst) |-> ch_count_stopped == '1 && ch_wptr == '1
    && ch_out_ptr == '1 && pattern_output_port == '0) else $error("outputs wrong after reset");
  a_start_step: assert property (ch_mode[0] != 2'h3 && (trig_edge_rise ? $rose(external_trigger_pin)
    : $fell(external_trigger_pin)) |=> !ch_count_stopped[0] && ch_busy[0]
    && ch_out_ptr[0] == ($past(ch_out_ptr[0]) == 3'h0 ? $past(top0) : $past(ch_out_ptr[0]) - 3'h1))
    else $error("start did not launch the sequence");
  a_os_start: assert property (ch_mode[0] == 2'h3 && ch_trig_ext[0] && $changed(external_trigger_pin)
    |=> ch_out_ptr[0] == 3'h0 && !ch_count_stopped[0]) else $error("one-shot start wrong");
  a_ptr_step: assert property (ch_mode[0] != 2'h3 && $changed(ch_out_ptr[0]) && !$past(ch_ptr_wr[0])
    |-> ch_out_ptr[0] == ($past(ch_out_ptr[0]) == 3'h0 ? top0 : $past(ch_out_ptr[0]) - 3'h1))
    else $error("pointer step wrong");
  a_ptr_write: assert property (ch_ptr_wr[0] && ch_mode[0] != 2'h3 && ch_count_stopped[0]
    && $stable(external_trigger_pin) |=> ch_out_ptr[0] == $past(ch_ptr_data[0])) else $error("pointer write lost");
  a_os_ptr_lock: assert property (ch_ptr_wr[0] && ch_mode[0] == 2'h3 && ch_count_stopped[0]
    && $stable(external_trigger_pin) |=> $stable(ch_out_ptr[0])) else $error("one-shot pointer overwritten");
  a_os_done: assert property (ch_mode[0] == 2'h3 && $fell(ch_busy[0]) |-> ch_out_ptr[0] == 3'h1
    && ch_count_stopped[0]) else $error("one-shot end state wrong");
  a_irq_cause: assert property ($rose(ch_irq_flag[0]) |-> $changed(ch_out_ptr[0]))
    else $error("irq flag without reload");
  a_wptr_toggle: assert property (ch_lat_wr_hi[0] && !ch_wptr_preset[0] |=> ch_wptr[0] != $past(ch_wptr[0]))
    else $error("write pointer did not toggle");
  a_wptr_preset: assert property (ch_wptr_preset[0] |=> ch_wptr[0] == $past(ch_wptr_value[0]))
    else $error("write pointer preset lost");

  c_os_done: cover property (ch_mode[0] == 2'h3 && $fell(ch_busy[0]));
  c_irq: cover property ($rose(ch_irq_flag[0]));
  c_wrap: cover property (ch_mode[0] != 2'h3 && $changed(ch_out_ptr[0]) && ch_out_ptr[0] == top0);
endmodule : rpo_top_checker

bind rpo_top rpo_top_checker #(.NCH(NCH)) u_rpo_chk (
  .clk(clk), .srst(srst), .trig_edge_rise(trig_edge_rise), .external_trigger_pin(external_trigger_pin),
  .ch_mode(ch_mode), .ch_trig_ext(ch_trig_ext), .ch_ptr_wr(ch_ptr_wr), .ch_ptr_data(ch_ptr_data),
  .ch_lat_wr_hi(ch_lat_wr_hi), .ch_wptr_preset(ch_wptr_preset), .ch_wptr_value(ch_wptr_value),
  .ch_count_stopped(ch_count_stopped), .ch_out_ptr(ch_out_ptr), .ch_wptr(ch_wptr), .ch_irq_flag(ch_irq_flag),
  .ch_busy(ch_busy), .pattern_output_port(pattern_output_port)
);
`default_nettype wire

// File: verification/test_rpo_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_rpo_top;
  logic            clk = 1'b0;
  logic            srst, cnt_src_slow, trig_edge_rise, external_trigger_pin, pat_wr;
  logic      [2:0] pat_wr_idx, pat_rd_idx, q;
  logic      [7:0] pat_wr_data, pat_rd_data, lat_wdata;
  logic [1:0][1:0] ch_mode;
  logic [1:0]      ch_trig_ext, ch_stop_set, ch_ptr_wr, ch_irq_ptr_mode, ch_irq_clr, ch_lat_wr_lo, ch_lat_wr_hi;
  logic [1:0]      ch_wptr_preset, ch_wptr_value, ch_count_stopped, ch_wptr, ch_irq_flag, ch_rd_hi, ch_rd_lo;
  logic [1:0][2:0] ch_ptr_data, ch_irq_ptr_match, ch_out_ptr;
  logic [1:0][7:0] pattern_output_port, ch_rd_data;
  int              bad_count = 0;
  int              compares = 0;
  int              n;

  rpo_top uut (
    .clk, .srst, .cnt_src_slow, .trig_edge_rise, .external_trigger_pin, .pat_wr, .pat_wr_idx, .pat_wr_data,
    .pat_rd_idx, .pat_rd_data, .ch_mode, .ch_trig_ext, .ch_stop_set, .ch_ptr_wr, .ch_ptr_data, .ch_irq_ptr_mode,
    .ch_irq_ptr_match, .ch_irq_clr, .ch_lat_wr_lo, .ch_lat_wr_hi, .lat_wdata, .ch_wptr_preset, .ch_wptr_value,
    .ch_rd_hi, .ch_rd_lo, .ch_rd_data, .ch_count_stopped, .ch_out_ptr, .ch_wptr, .ch_irq_flag,
    .ch_busy(), .pattern_output_port
  );

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Both channels take the same bytes; low byte always goes first
  task automatic wlat(input logic [15:0] v);
    lat_wdata = v[7:0];
    ch_lat_wr_lo = 2'h3;
    cyc(1);
    ch_lat_wr_lo = 2'h0;
    ch_lat_wr_hi = 2'h3;
    lat_wdata = v[15:8];
    cyc(1);
    ch_lat_wr_hi = 2'h0;
  endtask : wlat

  // Bounded so a stuck sequencer shows up as a failed compare, not a hang
  task automatic wait_ptr(input int c);
    n = 0;
    while (ch_out_ptr[c] === q && n < 300) begin
      cyc(1);
      n++;
    end
  endtask : wait_ptr

  // The pin is set to the opposite level first, and that must not start anything
  task automatic trig(input logic rise, input int c);
    external_trigger_pin = ~rise;
    cyc(3);
    chk(ch_count_stopped[c], 1'b1);
    external_trigger_pin = rise;
    cyc(2);
  endtask : trig

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(pattern_output_port, 16'h0000);
    chk({ch_count_stopped, ch_wptr, ch_out_ptr}, {4'hF, 6'h3F});
  endtask : t_reset

  task automatic t_load;
    pat_wr = 1'b1;
    for (int i = 0; i < 8; i++) begin
      pat_wr_idx = 3'(i);
      pat_wr_data = 8'hC0 + 8'(i);
      cyc(1);
    end
    pat_wr = 1'b0;
    for (int i = 0; i < 8; i++) begin
      pat_rd_idx = 3'(i);
      cyc(1);
      chk(pat_rd_data, 8'hC0 + 8'(i));
    end
    ch_wptr_preset = 2'h3;
    cyc(1);
    ch_wptr_preset = 2'h0;
    chk(ch_wptr, 2'h0);
    wlat(16'h0002);
    chk(ch_wptr, 2'h3);
    wlat(16'h0003);
    chk(ch_wptr, 2'h0);
  endtask : t_load

  // Latch 0 holds 2 and latch 1 holds 3, so reload intervals are 3 and 4 count pulses
  task automatic t_rep(input int c, input logic [1:0] m, input logic [2:0] top, input logic r, s, pm);
    logic irq;
    ch_stop_set = 2'h3;
    cyc(1);
    ch_stop_set = 2'h0;
    ch_irq_clr = 2'h3;
    ch_mode[c] = m;
    trig_edge_rise = r;
    cnt_src_slow = s;
    ch_irq_ptr_mode[c] = pm;
    ch_irq_ptr_match[c] = top;
    ch_ptr_wr[c] = 1'b1;
    ch_ptr_data[c] = 3'h1;
    cyc(1);
    ch_irq_clr = 2'h0;
    ch_ptr_wr[c] = 1'b0;
    chk(ch_out_ptr[c], 3'h1);
    trig(r, c);
    q = 3'h1;
    irq = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        wait_ptr(c);
        irq = irq | !pm | (q == top);
        if (k > 1) chk(16'(n), 16'((k + 1) * (s ? 16 : 2)));
      end
      chk({pattern_output_port[c], ch_out_ptr[c], ch_count_stopped[c], ch_irq_flag[c]},
          {8'hC0 + 8'(q), (q == 3'h0) ? top : q - 3'h1, 1'b0, irq});
      q = (q == 3'h0) ? top : q - 3'h1;
    end
  endtask : t_rep

  task automatic os_chk(input logic [11:0] e);
    chk({pattern_output_port[0], ch_out_ptr[0], ch_count_stopped[0]}, e);
  endtask : os_chk

  task automatic t_os;
    ch_stop_set = 2'h3;
    cyc(1);
    ch_stop_set = 2'h0;
    ch_ptr_wr[0] = 1'b1;
    ch_ptr_data[0] = 3'h6;
    cyc(1);
    ch_mode[0] = 2'h3;
    ch_trig_ext[0] = 1'b1;
    ch_ptr_data[0] = 3'h2;
    cyc(1);
    ch_ptr_wr[0] = 1'b0;
    chk(ch_out_ptr[0], 3'h6);
    external_trigger_pin = 1'b1;
    cyc(2);
    os_chk({8'hC1, 3'h0, 1'b0});
    q = 3'h0;
    wait_ptr(0);
    os_chk({8'hC0, 3'h2, 1'b0});
    q = 3'h2;
    wait_ptr(0);
    os_chk({8'hC2, 3'h1, 1'b1});
    cyc(40);
    os_chk({8'hC2, 3'h1, 1'b1});
    ch_rd_hi[0] = 1'b1;
    cyc(1);
    ch_rd_hi[0] = 1'b0;
    chk(ch_rd_data[0], 8'h00);
    external_trigger_pin = 1'b0;
    cyc(2);
    os_chk({8'hC1, 3'h0, 1'b0});
    // The restart reloads 3 and counts down, so only the held byte can read 3 here
    cyc(2);
    ch_rd_lo[0] = 1'b1;
    cyc(1);
    ch_rd_lo[0] = 1'b0;
    chk(ch_rd_data[0], 8'h03);
  endtask : t_os

  // A pin held high across reset must not look like an edge afterwards
  task automatic t_rst_mid;
    srst = 1'b1;
    trig_edge_rise = 1'b1;
    external_trigger_pin = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(2);
    t_reset();
  endtask : t_rst_mid

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cnt_src_slow, trig_edge_rise, external_trigger_pin, pat_wr, pat_wr_idx, pat_wr_data, pat_rd_idx, lat_wdata} = '0;
    {ch_mode, ch_trig_ext, ch_stop_set, ch_ptr_wr, ch_ptr_data, ch_irq_ptr_mode, ch_irq_ptr_match, ch_irq_clr} = '0;
    {ch_lat_wr_lo, ch_lat_wr_hi, ch_wptr_preset, ch_wptr_value, ch_rd_hi, ch_rd_lo} = '0;
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(1);
    t_reset();
    t_load();
    t_rep(0, 2'h0, 3'h7, 1'b0, 1'b0, 1'b0);
    t_rep(1, 2'h1, 3'h5, 1'b1, 1'b1, 1'b1);
    t_rep(0, 2'h2, 3'h4, 1'b0, 1'b0, 1'b1);
    t_os();
    t_rst_mid();
    end_of_test();
  end

  // The whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(negedge clk);
    bad_count++;
    end_of_test();
  end
endmodule : test_rpo_top
`default_nettype wire
